/* File: verilog/cpst_pkg.sv */
// Package for the core power state and thermal control block.
// Assumes a single 20 MHz system bus clock and active-low async reset.
package cpst_pkg;

  // Clock rate and derived timing
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned CLK_NS = 1000000000 / CLK_HZ;
  // Trip level, degrees C, reported by the sensor comparator outside
  localparam int unsigned TRIP_DEG_C = 135;
  // Rail fall time to half nominal, seconds (platform side)
  localparam int unsigned RAIL_FALL_S = 5;

  // Synchroniser depth
  localparam int unsigned SYNC_STAGES = 2;
  // Length of the state-save phase in clocks
  localparam logic [3:0] SAVE_CYCLES = 4'h4;

  // Bus acknowledge transaction codes
  localparam logic [1:0] ACK_NONE = 2'h0;
  localparam logic [1:0] ACK_MGMT = 2'h1;
  localparam logic [1:0] ACK_WAIT = 2'h2;

  // Core operating states, one-hot
  typedef enum logic [6:0] {
    CPST_RUN     = 7'h01,
    CPST_SAVE    = 7'h02,
    CPST_MGMT_AK = 7'h04,
    CPST_HANDLER = 7'h08,
    CPST_WAIT_AK = 7'h10,
    CPST_WAIT    = 7'h20,
    CPST_SLEEP   = 7'h40
  } cpst_state_t;

  // Synchronised request levels, active high
  typedef struct packed {
    logic mgmt;
    logic halt;
    logic sleep;
  } cpst_req_t;

  // Acknowledge transaction towards the bus unit
  typedef struct packed {
    logic valid;
    logic [1:0] code;
  } cpst_ack_t;

  // Clock gate enables per unit group
  typedef struct packed {
    logic core;
    logic bus;
    logic intc;
    logic pll;
  } cpst_gate_t;

endpackage : cpst_pkg

/* File: verilog/cpst_sync.sv */
// Two-stage synchroniser for a bundle of asynchronous levels.
// Assumes inputs come from pins outside the mclk domain.
`timescale 1ns/10ps
module cpst_sync #(
  parameter int unsigned W = 3
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } cpst_sync_t;

  cpst_sync_t st;
  cpst_sync_t next_st;

  // Inactive value of every request is zero after the bundle's inversion
  always_comb begin
    next_st.meta = async_in;
    next_st.sync = st.meta;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.sync;

endmodule : cpst_sync

/* File: verilog/cpst_tap.sv */
// Minimal test access port: a one-bit bypass path from test data in to out.
// Runs on the test clock supplied by debug tools; reset by the test reset.
`timescale 1ns/10ps
module cpst_tap (
  // Test port
  input wire logic tck,
  input wire logic test_rst_n,
  input wire logic tdi,
  output logic tdo
);

  typedef struct packed {
    logic bypass;
    logic out;
  } cpst_tap_t;

  cpst_tap_t st;
  cpst_tap_t next_st;

  always_comb begin
    next_st.bypass = tdi;
    next_st.out = st.bypass;
  end

  // Data shifts in on the rising edge and leaves on the falling edge
  always_ff @(posedge tck or negedge test_rst_n) begin
    if (!test_rst_n) begin
      st.bypass <= 1'b0;
    end else begin
      st.bypass <= next_st.bypass;
    end
  end

  always_ff @(negedge tck or negedge test_rst_n) begin
    if (!test_rst_n) begin
      st.out <= 1'b0;
    end else begin
      st.out <= next_st.out;
    end
  end

  assign tdo = st.out;

endmodule : cpst_tap

/* File: verilog/cpst_ctrl.sv */
// Core power state and thermal control: management interrupt entry, stop-clock
// wait state, sleep, and latched thermal trip.
// Assumes requests arrive asynchronously on pins; the bus unit takes one ack
// pulse at a time; the sensor comparator output is an asynchronous level, synchronised like the requests.
`timescale 1ns/10ps
module cpst_ctrl (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Asynchronous requests from system logic
  input wire logic sys_mgmt_interrupt_n,
  input wire logic clock_halt_request_n,
  input wire logic deep_sleep_request_n,
  // Sensor and supply status
  input wire logic over_temp,
  input wire logic supplies_on,
  // Core handshakes
  input wire logic handler_done,
  input wire logic ack_taken,
  input wire logic snoop_req,
  input wire logic irq_in,
  // Test access port
  input wire logic tck,
  input wire logic test_rst_n,
  input wire logic tdi,
  output logic tdo,
  // Bus acknowledge transaction
  output cpst_pkg::cpst_ack_t bus_ack,
  // Core control
  output cpst_pkg::cpst_gate_t clk_gate,
  output logic core_exec,
  output logic state_save,
  output logic protected_management_mode,
  output logic snoop_ack,
  output logic irq_service,
  // Thermal trip
  output logic overheat_trip_n
);

  typedef struct packed {
    cpst_pkg::cpst_state_t state;
    logic [3:0] save_cnt;
    logic irq_pend;
    logic trip;
    cpst_pkg::cpst_ack_t ack;
    cpst_pkg::cpst_gate_t gate;
    logic exec;
    logic saving;
    logic mgmt_mode;
    logic snoop;
    logic service;
    logic trip_n;
  } cpst_ctrl_t;

  cpst_ctrl_t st;
  cpst_ctrl_t next_st;
  cpst_pkg::cpst_req_t req;
  logic [2:0] req_raw;
  logic [2:0] req_sync;
  logic [1:0] lvl_raw;
  logic [1:0] lvl_sync;
  logic hot;
  logic pwr;

  // Inverted so that reset value zero means "not requested"
  assign req_raw = {~sys_mgmt_interrupt_n, ~clock_halt_request_n, ~deep_sleep_request_n};

  cpst_sync #(.W(3)) u_req_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in(req_raw),
    .sync_out(req_sync)
  );

  // Sensor and supply status are sampled like any other pin
  assign lvl_raw = {over_temp, ~supplies_on};

  cpst_sync #(.W(2)) u_lvl_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in(lvl_raw),
    .sync_out(lvl_sync)
  );

  assign req = req_sync;
  assign hot = lvl_sync[1];
  assign pwr = ~lvl_sync[0];

  cpst_tap u_tap (
    .tck(tck),
    .test_rst_n(test_rst_n),
    .tdi(tdi),
    .tdo(tdo)
  );

  always_comb begin
    next_st = st;
    next_st.ack.valid = 1'b0;
    next_st.ack.code = cpst_pkg::ACK_NONE;
    next_st.snoop = 1'b0;
    next_st.service = 1'b0;

    unique case (st.state)
      cpst_pkg::CPST_RUN: begin
        if (req.mgmt) begin
          next_st.state = cpst_pkg::CPST_SAVE;
          next_st.save_cnt = cpst_pkg::SAVE_CYCLES;
        end else if (req.halt) begin
          next_st.state = cpst_pkg::CPST_WAIT_AK;
        end
      end
      cpst_pkg::CPST_SAVE: begin
        if (st.save_cnt == 4'h1) begin
          next_st.state = cpst_pkg::CPST_MGMT_AK;
        end
        next_st.save_cnt = st.save_cnt - 4'h1;
      end
      cpst_pkg::CPST_MGMT_AK: begin
        next_st.ack.valid = 1'b1;
        next_st.ack.code = cpst_pkg::ACK_MGMT;
        if (st.ack.valid && ack_taken) begin
          next_st.ack.valid = 1'b0;
          next_st.ack.code = cpst_pkg::ACK_NONE;
          next_st.state = cpst_pkg::CPST_HANDLER;
        end
      end
      cpst_pkg::CPST_HANDLER: begin
        if (handler_done) begin
          next_st.state = cpst_pkg::CPST_RUN;
        end
      end
      cpst_pkg::CPST_WAIT_AK: begin
        next_st.ack.valid = 1'b1;
        next_st.ack.code = cpst_pkg::ACK_WAIT;
        if (st.ack.valid && ack_taken) begin
          next_st.ack.valid = 1'b0;
          next_st.ack.code = cpst_pkg::ACK_NONE;
          next_st.state = cpst_pkg::CPST_WAIT;
        end
      end
      cpst_pkg::CPST_WAIT: begin
        next_st.snoop = snoop_req;
        if (!req.halt) begin
          next_st.state = cpst_pkg::CPST_RUN;
          next_st.service = st.irq_pend | irq_in;
          next_st.irq_pend = 1'b0;
        end else if (req.sleep) begin
          next_st.state = cpst_pkg::CPST_SLEEP;
        end
      end
      cpst_pkg::CPST_SLEEP: begin
        // Snoops and interrupts fall on the floor here
        if (!req.sleep) begin
          next_st.state = cpst_pkg::CPST_WAIT;
        end
      end
      default: begin
        next_st.state = cpst_pkg::CPST_RUN;
      end
    endcase

    // Interrupts latched in wait state while halt is held; on exit irq_in goes straight to service
    if (st.state == cpst_pkg::CPST_WAIT && irq_in && req.halt) begin
      next_st.irq_pend = 1'b1;
    end

    // Trip latches; only reset or supply loss clears it
    if (hot) begin
      next_st.trip = 1'b1;
    end else if (!pwr) begin
      next_st.trip = 1'b0;
    end

    // Freeze before the outputs are derived, so mode and save flags match the held state
    if (next_st.trip) begin
      next_st.ack.valid = 1'b0;
      next_st.ack.code = cpst_pkg::ACK_NONE;
      next_st.state = st.state;
      next_st.save_cnt = st.save_cnt;
      next_st.service = 1'b0;
      next_st.irq_pend = next_st.irq_pend | st.irq_pend;
    end

    next_st.gate.pll = 1'b1;
    next_st.gate.bus = (next_st.state != cpst_pkg::CPST_SLEEP);
    next_st.gate.intc = (next_st.state != cpst_pkg::CPST_SLEEP);
    next_st.gate.core = !next_st.trip && (next_st.state != cpst_pkg::CPST_WAIT)
                        && (next_st.state != cpst_pkg::CPST_SLEEP);
    next_st.exec = !next_st.trip && ((next_st.state == cpst_pkg::CPST_RUN)
                   || (next_st.state == cpst_pkg::CPST_HANDLER));
    next_st.saving = (next_st.state == cpst_pkg::CPST_SAVE);
    next_st.mgmt_mode = (next_st.state == cpst_pkg::CPST_SAVE)
                        || (next_st.state == cpst_pkg::CPST_MGMT_AK)
                        || (next_st.state == cpst_pkg::CPST_HANDLER);
    next_st.trip_n = !(next_st.trip && pwr);
  end

  // Reset clears the trip; a still-hot sensor sets it again three clocks
  // later through the synchroniser, so the halt persists
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st.state <= cpst_pkg::CPST_RUN;
      st.save_cnt <= 4'h0;
      st.irq_pend <= 1'b0;
      st.trip <= 1'b0;
      st.ack <= '0;
      st.gate <= 4'hf;
      st.exec <= 1'b1;
      st.saving <= 1'b0;
      st.mgmt_mode <= 1'b0;
      st.snoop <= 1'b0;
      st.service <= 1'b0;
      st.trip_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign bus_ack = st.ack;
  assign clk_gate = st.gate;
  assign core_exec = st.exec;
  assign state_save = st.saving;
  assign protected_management_mode = st.mgmt_mode;
  assign snoop_ack = st.snoop;
  assign irq_service = st.service;
  assign overheat_trip_n = st.trip_n;

endmodule : cpst_ctrl

/* File: tb/cpst_ctrl_properties.sv */
// Port assertions for the power state and thermal control block.
// Assumes one mclk domain with active-low async reset rst_n.
`timescale 1ns/10ps
module cpst_ctrl_properties (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Inputs
  input wire logic clock_halt_request_n,
  input wire logic over_temp,
  input wire logic supplies_on,
  input wire logic ack_taken,
  input wire logic snoop_req,
  // Outputs
  input wire cpst_pkg::cpst_ack_t bus_ack,
  input wire cpst_pkg::cpst_gate_t clk_gate,
  input wire logic core_exec,
  input wire logic state_save,
  input wire logic protected_management_mode,
  input wire logic snoop_ack,
  input wire logic overheat_trip_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_save;
    state_save[*4] ##1 !state_save;
  endsequence
  sequence s_hot;
    (over_temp && supplies_on)[*5];
  endsequence
  sequence s_sleep;
    clk_gate == 4'h1 ##1 !snoop_ack;
  endsequence
  save_len_a: assert property ($rose(state_save) |-> s_save ##1 bus_ack == 3'h5)
    else $error("save or ack late");
  ack_hold_a: assert property (bus_ack.valid && !ack_taken && overheat_trip_n |=>
    $stable(bus_ack) || !overheat_trip_n) else $error("ack dropped");
  halt_in_a: assert property ($fell(clock_halt_request_n) && core_exec &&
    overheat_trip_n && !protected_management_mode |-> ##[2:4] bus_ack == 3'h6)
    else $error("no wait ack");
  wait_gate_a: assert property (bus_ack == 3'h6 && ack_taken |=>
    clk_gate == 4'h7 && !core_exec) else $error("wait gates");
  snoop_only_a: assert property (snoop_ack |->
    $past(snoop_req) && !$past(clk_gate.core)) else $error("stray snoop ack");
  sleep_quiet_a: assert property (!clk_gate.bus |-> s_sleep)
    else $error("sleep not quiet");
  save_mode_a: assert property (state_save |-> protected_management_mode && !core_exec)
    else $error("save outside mode");
  wait_out_a: assert property ($rose(clock_halt_request_n) && clk_gate == 4'h7 |->
    ##[2:5] core_exec && clk_gate.core) else $error("no wait exit");
  trip_set_a: assert property (s_hot |-> !overheat_trip_n && !core_exec)
    else $error("no trip");
  trip_hold_a: assert property (!overheat_trip_n && supplies_on |=> !overheat_trip_n)
    else $error("trip lost");
  trip_free_a: assert property (!supplies_on && !overheat_trip_n |-> ##[1:4] overheat_trip_n)
    else $error("trip kept");
endmodule : cpst_ctrl_properties
bind cpst_ctrl cpst_ctrl_properties chk_u (.*);

/* File: tb/cpst_sys_model.sv */
// System logic and platform power model facing the block.
// Assumes the bench sets wishes; request and sensor pins move off the clock edge, supplies_on moves on it.
`timescale 1ns/10ps
module cpst_sys_model #(
  parameter int FALL_CYC = 12
) (
  // Clock, trip and wishes
  input wire logic mclk,
  input wire logic overheat_trip_n,
  input wire logic [3:0] want,
  // Pins to the device
  output logic sys_mgmt_interrupt_n,
  output logic clock_halt_request_n,
  output logic deep_sleep_request_n,
  output logic over_temp,
  output logic supplies_on
);
  int cnt = 0;
  logic off = 0;
  initial {sys_mgmt_interrupt_n, clock_halt_request_n, deep_sleep_request_n, over_temp} = 4'he;
  // Skewed from mclk: system logic is not bus-timed
  always @(want) #7 {sys_mgmt_interrupt_n, clock_halt_request_n, deep_sleep_request_n,
    over_temp} = {~want[3:1], want[0]};
  // Rails stay off while hot, so the trip release cannot cycle power
  always @(posedge mclk) begin
    cnt <= overheat_trip_n ? 0 : cnt + 1;
    off <= (off && want[0]) || cnt == FALL_CYC;
  end
  assign supplies_on = !off;
endmodule : cpst_sys_model

/* File: tb/test_core_power_state_thermal_control.sv */
// Self-checking bench for the power state and thermal control block.
// Assumes the system model drives request pins and supply status.
`timescale 1ns/10ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin failures++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
`define AWAIT(c) begin for (int k = 0; k < 40 && (c) !== 1'b1; k++) tick(1); \
  if ((c) !== 1'b1) begin failures++; give_verdict(); end end
module test_core_power_state_thermal_control;
  logic mclk = 0, rst_n = 0, handler_done = 0, ack_taken = 0, snoop_req = 0, irq_in = 0;
  logic tck = 0, test_rst_n = 0, tdi = 0, tdo, core_exec, state_save, snoop_ack, irq_service;
  logic protected_management_mode, overheat_trip_n, sys_mgmt_interrupt_n, clock_halt_request_n;
  logic deep_sleep_request_n, over_temp, supplies_on;
  logic [3:0] want = 0;
  cpst_pkg::cpst_ack_t bus_ack;
  cpst_pkg::cpst_gate_t clk_gate;
  int failures = 0, checks_done = 0;
  always #25 mclk = ~mclk;
  cpst_ctrl dut_u (.*);
  cpst_sys_model #(.FALL_CYC(12)) sys_u (.*);
  task automatic tick(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  task automatic give_verdict();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  function automatic logic [3:0] exp_gate(bit halt, bit sleep);
    return halt ? (sleep ? 4'h1 : 4'h7) : 4'hf;
  endfunction : exp_gate
  task automatic take_ack(logic [1:0] code);
    `AWAIT(bus_ack.valid)
    `CHK("ack code", code, bus_ack.code)
    @(posedge mclk) ack_taken <= 1;
    @(posedge mclk) ack_taken <= 0;
  endtask : take_ack
  task automatic pulse_in();
    @(posedge mclk) {snoop_req, irq_in} <= 2'h3;
    @(posedge mclk) {snoop_req, irq_in} <= 2'h0;
    #1;
  endtask : pulse_in
  initial begin
    void'($urandom(32'h1eda3df4));
    repeat (3) @(posedge mclk);
    {rst_n, test_rst_n} <= 2'h3;
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk) want[3] <= 1;
      `AWAIT(state_save)
      `CHK("mode", 1'b1, protected_management_mode)
      @(posedge mclk) want[2] <= i[0];
      take_ack(cpst_pkg::ACK_MGMT);
      tick(2);
      `CHK("handler", 1'b1, core_exec)
      @(posedge mclk) want[3] <= 0;
      // Handler ends only once the released request has passed the synchroniser
      repeat (1 + $urandom_range(5)) @(posedge mclk);
      handler_done <= 1;
      @(posedge mclk) handler_done <= 0;
      #1;
      `CHK("mode off", 1'b0, protected_management_mode)
      if (i[0]) begin
        take_ack(cpst_pkg::ACK_WAIT);
        tick(2);
        `CHK("gates", exp_gate(1, 0), clk_gate)
        pulse_in();
        `CHK("snoop", 1'b1, snoop_ack)
        @(posedge mclk) want[1] <= 1;
        `AWAIT(clk_gate.bus === 1'b0)
        `CHK("sleep gates", exp_gate(1, 1), clk_gate)
        pulse_in();
        `CHK("sleep snoop", 1'b0, snoop_ack)
        @(posedge mclk) want[1] <= 0;
        `AWAIT(clk_gate.bus)
        `CHK("back", exp_gate(1, 0), clk_gate)
        @(posedge mclk) want[2] <= 0;
        `AWAIT(irq_service)
        tick(2);
        `CHK("resume", exp_gate(0, 0), clk_gate)
      end
      $display("mgmt test %0d done", i);
    end
    @(posedge mclk) want[0] <= 1;
    `AWAIT(overheat_trip_n === 1'b0)
    `CHK("trip halt", 1'b0, core_exec)
    @(posedge mclk) rst_n <= 0;
    @(posedge mclk) rst_n <= 1;
    tick(5);
    `CHK("hot reset", 1'b0, overheat_trip_n)
    `AWAIT(overheat_trip_n)
    `CHK("rails", 1'b0, supplies_on)
    @(posedge mclk) want[0] <= 0;
    `AWAIT(supplies_on)
    @(posedge mclk) rst_n <= 0;
    @(posedge mclk) rst_n <= 1;
    tick(5);
    `CHK("cool", 2'h3, {core_exec, overheat_trip_n})
    $display("trip test done");
    for (int i = 0; i < 8; i++) begin
      tdi = 1'($urandom);
      #5 tck = 1;
      #5 tck = 0;
      #1;
      `CHK("tdo", tdi, tdo)
    end
    $display("tap test done");
    give_verdict();
  end
endmodule : test_core_power_state_thermal_control
